// ### logic/rsq_defines.vh
// Constants for the reset source sequencer: register map, field positions,
// reset values and timing counts derived from the 200 MHz pclk.
// Assumes inclusion by bare name from the design files.
//
// Function
// - Four reset sources: pin, soft, PHY twice
// - External pin resets everything, reloads, relatches straps
// - Soft reset: interface, MAC, reload; rest kept
// - Config bit 0 starts soft reset, clears ~2us
// - Power control bit 10 resets PHY only
// - PHY reset bit clears after ~100us
// - PHY control bit 15 resets PHY, self-clears
// - Ready reads zero during hardware reset
// - Ready set ~22ms after hardware reset
// - Ready set within 2ms after wake write
// - EEPROM probe after pin and soft resets, busy flag set
// - Only external pin or power-up reset relatches configuration straps
`ifndef RSQ_DEFINES_VH
`define RSQ_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RSQ_OFS_HARDWARE_CONFIG_REG      12'h000
`define RSQ_OFS_POWER_MGMT_CONTROL_REG    12'h004
`define RSQ_OFS_PHY_BCR     12'h008
`define RSQ_OFS_EEPROM_COMMAND_REG     12'h00C
`define RSQ_OFS_WAKE_TEST   12'h010
`define RSQ_OFS_STRAPS      12'h014
`define RSQ_OFS_RST_STAT    12'h018

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RSQ_HARDWARE_CONFIG_REG_SOFT_RESET_REQUEST_BIT     0
`define RSQ_PMT_READY       0
`define RSQ_PMT_PHY_RST     10
`define RSQ_PMT_PM_LO       12
`define RSQ_PMT_PM_HI       13
`define RSQ_BCR_RESET       15
`define RSQ_E2P_BUSY        31

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RSQ_PM_MODE_RST     2'h0
`define RSQ_STRAPS_RST      8'h00
`define RSQ_RDATA_RST       32'h00000000

// ----------------------------------------------------------------------------
// Timing: times in microseconds, counts in pclk cycles
// ----------------------------------------------------------------------------
`define RSQ_CLK_MHZ         200
`define RSQ_SOFT_RESET_REQUEST_BIT_US         2
`define RSQ_PHY_RST_US      100
`define RSQ_READY_US        22000
`define RSQ_WAKE_US         2000
`define RSQ_SOFT_RESET_REQUEST_BIT_CYC        (`RSQ_SOFT_RESET_REQUEST_BIT_US * `RSQ_CLK_MHZ)
`define RSQ_PHY_RST_CYC     (`RSQ_PHY_RST_US * `RSQ_CLK_MHZ)
`define RSQ_READY_CYC       (`RSQ_READY_US * `RSQ_CLK_MHZ)
`define RSQ_WAKE_CYC        (`RSQ_WAKE_US * `RSQ_CLK_MHZ)
`define RSQ_PROBE_CYC       1000
`define RSQ_TMR_W           23

`endif

// ### logic/rsq_timer.v
// Down-counting interval timer for the reset sequencer.
// Assumes start and load are stable in the cycle start is high.
`timescale 1ns/1ps
`default_nettype none
`include "rsq_defines.vh"

module rsq_timer (
   // Clock and reset
   input  wire                   pclk,
   input  wire                   presetn,
   // Control
   input  wire                   clr,
   input  wire                   start,
   input  wire [`RSQ_TMR_W-1:0]  load,
   // Status
   output wire                   busy,
   output reg                    done_q
);

   // ---------------------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------------------
   reg [`RSQ_TMR_W-1:0] cnt_q;
   reg                  run_q;

   assign busy = run_q;

   // Runs for exactly load cycles, then pulses done for one cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= {`RSQ_TMR_W{1'b0}};
         run_q  <= 1'b0;
         done_q <= 1'b0;
      end else if (clr) begin
         cnt_q  <= {`RSQ_TMR_W{1'b0}};
         run_q  <= 1'b0;
         done_q <= 1'b0;
      end else if (start) begin
         cnt_q  <= load;
         run_q  <= 1'b1;
         done_q <= 1'b0;
      end else if (run_q && cnt_q <= {{(`RSQ_TMR_W-1){1'b0}}, 1'b1}) begin
         cnt_q  <= {`RSQ_TMR_W{1'b0}};
         run_q  <= 1'b0;
         done_q <= 1'b1;
      end else begin
         cnt_q  <= run_q ? cnt_q - {{(`RSQ_TMR_W-1){1'b0}}, 1'b1} : cnt_q;
         done_q <= 1'b0;
      end
   end

endmodule // rsq_timer
`default_nettype wire

// ### logic/rsq_top.v
// Reset source sequencer: APB register slave, reset steering to the
// device's sub-blocks, ready flag, EEPROM probe busy flag and strap latch.
// Assumes pclk at 200 MHz and the external reset pin already synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "rsq_defines.vh"

module rsq_top #(
   parameter [`RSQ_TMR_W-1:0] SOFT_RESET_REQUEST_BIT_CYC    = `RSQ_SOFT_RESET_REQUEST_BIT_CYC,
   parameter [`RSQ_TMR_W-1:0] PHY_RST_CYC = `RSQ_PHY_RST_CYC,
   parameter [`RSQ_TMR_W-1:0] READY_CYC   = `RSQ_READY_CYC,
   parameter [`RSQ_TMR_W-1:0] WAKE_CYC    = `RSQ_WAKE_CYC,
   parameter [`RSQ_TMR_W-1:0] PROBE_CYC   = `RSQ_PROBE_CYC
) (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   // Reset sources and straps
   input  wire        external_reset_in_n,
   input  wire [7:0]  strap_in,
   // Reset outputs to sub-blocks
   output reg         pll_rst_q,
   output reg         hbi_rst_q,
   output reg         reset_exempt_marker_rst_q,
   output reg         mil_rst_q,
   output reg         mac_rst_q,
   output reg         phy_rst_q,
   output reg         eeprom_reload_q,
   output reg  [7:0]  straps_q,
   // Status
   output reg         ready_q,
   output reg         eeprom_busy_flag_q,
   output reg  [1:0]  pm_mode_q
);

   // ---------------------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------------------
   wire acc    = psel & penable;
   wire wr     = acc & pwrite;
   wire hit_hw = (paddr == `RSQ_OFS_HARDWARE_CONFIG_REG);
   wire hit_pm = (paddr == `RSQ_OFS_POWER_MGMT_CONTROL_REG);
   wire hit_bc = (paddr == `RSQ_OFS_PHY_BCR);
   wire hit_ee = (paddr == `RSQ_OFS_EEPROM_COMMAND_REG);
   wire hit_wk = (paddr == `RSQ_OFS_WAKE_TEST);
   wire hit_st = (paddr == `RSQ_OFS_STRAPS);
   wire hit_rs = (paddr == `RSQ_OFS_RST_STAT);
   wire mapped = hit_hw | hit_pm | hit_bc | hit_ee | hit_wk | hit_st | hit_rs;

   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   // ---------------------------------------------------------------------------
   // External reset tracking
   // ---------------------------------------------------------------------------
   reg ext_act_q;
   reg ext_prev_q;
   reg por_q;

   // Pin held low keeps the whole device in reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_act_q  <= 1'b1;
         ext_prev_q <= 1'b1;
         por_q      <= 1'b1;
      end else begin
         ext_act_q  <= ~external_reset_in_n;
         ext_prev_q <= ext_act_q;
         por_q      <= 1'b0;
      end
   end

   // End of a hardware reset: pin release or first cycle after power-up
   wire hw_rel = (ext_prev_q & ~ext_act_q) | (por_q & ~ext_act_q);

   // ---------------------------------------------------------------------------
   // Self-clearing request bits
   // ---------------------------------------------------------------------------
   reg  soft_reset_request_bit_q;
   reg  phy_req_q;
   reg  bcr_req_q;
   wire soft_reset_request_bit_done;
   wire phy_done;
   wire bcr_done;
   wire ready_done;
   wire probe_done;
   wire soft_reset_request_bit_busy;
   wire phy_busy;
   wire bcr_busy;
   wire ready_busy;
   wire probe_busy;

   wire wr_soft_reset_request_bit = wr & hit_hw & pwdata[`RSQ_HARDWARE_CONFIG_REG_SOFT_RESET_REQUEST_BIT] & ~soft_reset_request_bit_q;
   wire wr_phy  = wr & hit_pm & pwdata[`RSQ_PMT_PHY_RST] & ~phy_req_q;
   wire wr_bcr  = wr & hit_bc & pwdata[`RSQ_BCR_RESET] & ~bcr_req_q;
   wire wr_pm   = wr & hit_pm & (pwdata[`RSQ_PMT_PM_HI:`RSQ_PMT_PM_LO] != 2'h0);
   wire wr_wake = wr & hit_wk & (pm_mode_q != 2'h0);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_reset_request_bit_q    <= 1'b0;
         phy_req_q <= 1'b0;
         bcr_req_q <= 1'b0;
      end else if (ext_act_q) begin
         soft_reset_request_bit_q    <= 1'b0;
         phy_req_q <= 1'b0;
         bcr_req_q <= 1'b0;
      end else begin
         if (wr_soft_reset_request_bit)
            soft_reset_request_bit_q <= 1'b1;
         else if (soft_reset_request_bit_done)
            soft_reset_request_bit_q <= 1'b0;
         if (wr_phy)
            phy_req_q <= 1'b1;
         else if (phy_done)
            phy_req_q <= 1'b0;
         if (wr_bcr)
            bcr_req_q <= 1'b1;
         else if (bcr_done)
            bcr_req_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------------
   // Interval timers
   // ---------------------------------------------------------------------------
   wire       probe_start = hw_rel | soft_reset_request_bit_done;
   wire       rdy_start   = hw_rel | wr_wake;
   wire [`RSQ_TMR_W-1:0] rdy_load = hw_rel ? READY_CYC : WAKE_CYC;

   rsq_timer u_soft_reset_request_bit_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (ext_act_q),
      .start   (wr_soft_reset_request_bit),
      .load    (SOFT_RESET_REQUEST_BIT_CYC),
      .busy    (soft_reset_request_bit_busy),
      .done_q  (soft_reset_request_bit_done)
   );

   rsq_timer u_phy_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (ext_act_q),
      .start   (wr_phy),
      .load    (PHY_RST_CYC),
      .busy    (phy_busy),
      .done_q  (phy_done)
   );

   rsq_timer u_bcr_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (ext_act_q),
      .start   (wr_bcr),
      .load    (PHY_RST_CYC),
      .busy    (bcr_busy),
      .done_q  (bcr_done)
   );

   rsq_timer u_rdy_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (ext_act_q),
      .start   (rdy_start),
      .load    (rdy_load),
      .busy    (ready_busy),
      .done_q  (ready_done)
   );

   rsq_timer u_probe_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (ext_act_q),
      .start   (probe_start),
      .load    (PROBE_CYC),
      .busy    (probe_busy),
      .done_q  (probe_done)
   );

   // ---------------------------------------------------------------------------
   // Ready flag, power mode, EEPROM busy
   // ---------------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_q            <= 1'b0;
         pm_mode_q          <= `RSQ_PM_MODE_RST;
         eeprom_busy_flag_q <= 1'b0;
      end else if (ext_act_q) begin
         ready_q            <= 1'b0;
         pm_mode_q          <= `RSQ_PM_MODE_RST;
         eeprom_busy_flag_q <= 1'b0;
      end else begin
         if (ready_done)
            ready_q <= 1'b1;
         else if (wr_soft_reset_request_bit || wr_pm)
            ready_q <= 1'b0;
         else if (soft_reset_request_bit_done)
            ready_q <= 1'b1;
         if (wr_wake)
            pm_mode_q <= `RSQ_PM_MODE_RST;
         else if (wr_pm)
            pm_mode_q <= pwdata[`RSQ_PMT_PM_HI:`RSQ_PMT_PM_LO];
         if (probe_start)
            eeprom_busy_flag_q <= 1'b1;
         else if (probe_done)
            eeprom_busy_flag_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------------
   // Reset steering and strap latch
   // ---------------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_rst_q       <= 1'b1;
         hbi_rst_q       <= 1'b1;
         reset_exempt_marker_rst_q      <= 1'b1;
         mil_rst_q       <= 1'b1;
         mac_rst_q       <= 1'b1;
         phy_rst_q       <= 1'b1;
         eeprom_reload_q <= 1'b0;
      end else begin
         pll_rst_q       <= ext_act_q;
         reset_exempt_marker_rst_q      <= ext_act_q;
         hbi_rst_q       <= ext_act_q | soft_reset_request_bit_q;
         mil_rst_q       <= ext_act_q | soft_reset_request_bit_q;
         mac_rst_q       <= ext_act_q | soft_reset_request_bit_q;
         phy_rst_q       <= ext_act_q | phy_req_q | bcr_req_q;
         eeprom_reload_q <= probe_start;
      end
   end

   // Straps taken only at the end of a pin or power-up reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         straps_q <= `RSQ_STRAPS_RST;
      else if (hw_rel)
         straps_q <= strap_in;
   end

   // ---------------------------------------------------------------------------
   // Read data, captured in the setup cycle
   // ---------------------------------------------------------------------------
   reg [31:0] rd_d;

   always @* begin
      rd_d = `RSQ_RDATA_RST;
      case (1'b1)
         hit_hw: rd_d[`RSQ_HARDWARE_CONFIG_REG_SOFT_RESET_REQUEST_BIT] = soft_reset_request_bit_q;
         hit_pm: begin
            rd_d[`RSQ_PMT_READY]                 = ready_q;
            rd_d[`RSQ_PMT_PHY_RST]               = phy_req_q;
            rd_d[`RSQ_PMT_PM_HI:`RSQ_PMT_PM_LO]  = pm_mode_q;
         end
         hit_bc: rd_d[`RSQ_BCR_RESET] = bcr_req_q;
         hit_ee: rd_d[`RSQ_E2P_BUSY]  = eeprom_busy_flag_q;
         hit_st: rd_d[7:0]            = straps_q;
         hit_rs: rd_d[6:0] = {eeprom_reload_q, phy_rst_q, mac_rst_q, mil_rst_q,
                              reset_exempt_marker_rst_q, hbi_rst_q, pll_rst_q};
         default: rd_d = `RSQ_RDATA_RST;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= `RSQ_RDATA_RST;
      else if (psel && !penable && !pwrite)
         prdata <= rd_d;
   end

endmodule // rsq_top
`default_nettype wire

// ### dv/rsq_chk.sv
// Concurrent checks on the reset sequencer top-level ports.
// Assumes one pclk domain, presetn async active low; bound to rsq_top.
`timescale 1ns/1ps
`default_nettype none
module rsq_chk #(
   parameter int SOFT_RESET_REQUEST_BIT_CYC    = 400,
   parameter int PHY_RST_CYC = 20000,
   parameter int READY_CYC   = 4400000,
   parameter int WAKE_CYC    = 400000
) (
   // Clock, reset and APB
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   // Reset pin and outputs
   input wire logic        external_reset_in_n,
   input wire logic        pll_rst_q,
   input wire logic        reset_exempt_marker_rst_q,
   input wire logic        hbi_rst_q,
   input wire logic        mil_rst_q,
   input wire logic        mac_rst_q,
   input wire logic        phy_rst_q,
   input wire logic        eeprom_reload_q,
   input wire logic        eeprom_busy_flag_q,
   input wire logic [7:0]  straps_q,
   input wire logic        ready_q,
   input wire logic [1:0]  pm_mode_q
);
   localparam int LIM = READY_CYC + SOFT_RESET_REQUEST_BIT_CYC + WAKE_CYC + 8;
   logic [3:0] hi_cnt;
   int         mil_cnt;
   int         phy_cnt;
   int         nrdy_cnt;
   // ---------------------------------------------------------------------
   // Helper counters
   // ---------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_cnt   <= 4'h0;
         mil_cnt  <= 0;
         phy_cnt  <= 0;
         nrdy_cnt <= 0;
      end else begin
         hi_cnt   <= !external_reset_in_n ? 4'h0 : (hi_cnt == 4'hF ? hi_cnt : hi_cnt + 4'h1);
         mil_cnt  <= mil_rst_q ? mil_cnt + 1 : 0;
         phy_cnt  <= phy_rst_q ? phy_cnt + 1 : 0;
         nrdy_cnt <= (ready_q || pm_mode_q != 2'h0 || !external_reset_in_n) ? 0 : nrdy_cnt + 1;
      end
   end
   // ---------------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence busy_s;
      ##[0:4] eeprom_busy_flag_q;
   endsequence
   apb_resp_a: assert property (psel && penable && paddr[1:0] == 2'h0 |->
      pready && (pslverr == (paddr > 12'h018))) else $error("bad APB response");
   pin_reset_a: assert property ($fell(external_reset_in_n) |-> ##2 (pll_rst_q && reset_exempt_marker_rst_q
      && hbi_rst_q && mil_rst_q && mac_rst_q && phy_rst_q)) else $error("pin reset not spread");
   pin_only_a: assert property (hi_cnt > 4'h5 |-> !pll_rst_q && !reset_exempt_marker_rst_q)
      else $error("pll or exempt reset without pin");
   strap_hold_a: assert property (hi_cnt > 4'h5 |-> $stable(straps_q))
      else $error("straps changed without pin reset");
   ready_low_a: assert property (!external_reset_in_n [*3] |-> !ready_q)
      else $error("ready set during pin reset");
   ready_bound_a: assert property (nrdy_cnt <= LIM)
      else $error("ready late");
   soft_reset_request_bit_len_a: assert property ($fell(mil_rst_q) && hi_cnt > 4'h5 |->
      mil_cnt >= SOFT_RESET_REQUEST_BIT_CYC && mil_cnt <= SOFT_RESET_REQUEST_BIT_CYC + 2) else $error("soft reset length");
   phy_len_a: assert property ($fell(phy_rst_q) && hi_cnt > 4'h5 |->
      phy_cnt >= PHY_RST_CYC && phy_cnt <= PHY_RST_CYC + 2) else $error("PHY reset length");
   phy_only_a: assert property ($rose(phy_rst_q) && hi_cnt > 4'h5 |->
      !mil_rst_q && !hbi_rst_q && !mac_rst_q) else $error("PHY reset spread");
   soft_reset_request_bit_keep_a: assert property ($rose(mil_rst_q) && hi_cnt > 4'h5 |-> !phy_rst_q)
      else $error("soft reset hit PHY");
   busy_soft_reset_request_bit_a: assert property ($fell(mil_rst_q) && hi_cnt > 4'h5 |-> busy_s)
      else $error("no probe after soft reset");
   reload_pulse_a: assert property (eeprom_reload_q |=> !eeprom_reload_q)
      else $error("reload pulse too long");
endmodule // rsq_chk
bind rsq_top rsq_chk #(.SOFT_RESET_REQUEST_BIT_CYC(SOFT_RESET_REQUEST_BIT_CYC), .PHY_RST_CYC(PHY_RST_CYC),
   .READY_CYC(READY_CYC), .WAKE_CYC(WAKE_CYC)) u_rsq_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .external_reset_in_n(external_reset_in_n), .pll_rst_q(pll_rst_q), .reset_exempt_marker_rst_q(reset_exempt_marker_rst_q),
   .hbi_rst_q(hbi_rst_q), .mil_rst_q(mil_rst_q), .mac_rst_q(mac_rst_q), .phy_rst_q(phy_rst_q),
   .eeprom_reload_q(eeprom_reload_q), .eeprom_busy_flag_q(eeprom_busy_flag_q),
   .straps_q(straps_q), .ready_q(ready_q), .pm_mode_q(pm_mode_q));
`default_nettype wire

// ### dv/rsq_host.sv
// Host model: APB master, reset pin and strap drivers.
// Assumes tasks are called one at a time per bus.
`timescale 1ns/1ps
`default_nettype none
module rsq_host (
   // Clock and APB answer
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   // APB request
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   // Pins
   output logic             external_reset_in_n,
   output logic [7:0]       strap_in
);
   // ---------------------------------------------------------------------
   // Bus and pin tasks
   // ---------------------------------------------------------------------
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      external_reset_in_n = 1'b1;
      strap_in = 8'hA5;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines show a changed value, not the last one
      paddr <= ~a;
      pwdata <= ~d;
   endtask
   // Polls a bit until it reads v; used for ready and busy waits
   task automatic poll(input logic [11:0] a, input int b, input logic v, output logic ok);
      logic [31:0] r;
      logic        e;
      int          i;
      ok = 1'b0;
      for (i = 0; i < 1000 && !ok; i++) begin
         xfer(1'b0, a, 32'h0, r, e);
         ok = (r[b] === v);
      end
   endtask
   task automatic pin_reset(input int n, input logic [7:0] s);
      @(posedge pclk);
      external_reset_in_n <= 1'b0;
      strap_in <= s;
      repeat (n) @(posedge pclk);
      external_reset_in_n <= 1'b1;
   endtask
   task automatic set_straps(input logic [7:0] s);
      @(posedge pclk);
      strap_in <= s;
   endtask
endmodule // rsq_host
`default_nettype wire

// ### dv/rsq_top_tb.sv
// Testbench for rsq_top: register sequences through the host model.
// Assumes short timer parameters and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "rsq_defines.vh"
module rsq_top_tb;
   localparam int SOFT_RESET_REQUEST_BIT = 400, PHY = 50, RDY = 100, WAKE = 60;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, ext_n, e, ok;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [7:0]  strap_in;
   int          n_fail = 0;
   int          n_tests = 0;
   int          i, el;
   realtime     t0;
   logic [11:0] ta [3] = '{`RSQ_OFS_HARDWARE_CONFIG_REG, `RSQ_OFS_POWER_MGMT_CONTROL_REG, `RSQ_OFS_PHY_BCR};
   int          tb  [3] = '{`RSQ_HARDWARE_CONFIG_REG_SOFT_RESET_REQUEST_BIT, `RSQ_PMT_PHY_RST, `RSQ_BCR_RESET};
   int          td  [3] = '{SOFT_RESET_REQUEST_BIT, PHY, PHY};
   logic [31:0] ts  [3] = '{32'h1A, 32'h20, 32'h20};
   always #2.5 pclk = ~pclk;
   rsq_host u_rsq_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .external_reset_in_n(ext_n), .strap_in(strap_in));
   rsq_top #(.SOFT_RESET_REQUEST_BIT_CYC(SOFT_RESET_REQUEST_BIT), .PHY_RST_CYC(PHY), .READY_CYC(RDY), .WAKE_CYC(WAKE),
      .PROBE_CYC(20)) u_rsq_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .external_reset_in_n(ext_n), .strap_in(strap_in),
      .pll_rst_q(), .hbi_rst_q(), .reset_exempt_marker_rst_q(), .mil_rst_q(), .mac_rst_q(), .phy_rst_q(),
      .eeprom_reload_q(), .straps_q(), .ready_q(), .eeprom_busy_flag_q(), .pm_mode_q());
   // ---------------------------------------------------------------------
   // Check helpers
   // ---------------------------------------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic        x;
      u_rsq_host.xfer(1'b0, a, 32'h0, d, x);
      cmp(d, exp);
      cmp(x, a > 12'h018);
   endtask
   task automatic wbit(input logic [11:0] a, input int b, input logic v);
      u_rsq_host.poll(a, b, v, ok);
      cmp(ok, 1'b1);
      el = int'(($realtime - t0) / 5.0);
   endtask
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      tally_and_finish;
   end
   // ---------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t0 = $realtime;
      rd(`RSQ_OFS_POWER_MGMT_CONTROL_REG, 32'h0);
      wbit(`RSQ_OFS_POWER_MGMT_CONTROL_REG, 0, 1'b1);
      cmp(el <= RDY + 8, 1'b1);
      wbit(`RSQ_OFS_EEPROM_COMMAND_REG, 31, 1'b0);
      rd(`RSQ_OFS_STRAPS, 32'hA5);
      rd(`RSQ_OFS_RST_STAT, 32'h0);
      u_rsq_host.set_straps(8'h3C);
      // Soft reset, PHY reset by power control, PHY reset by PHY control
      for (i = 0; i < 3; i++) begin
         u_rsq_host.xfer(1'b1, ta[i], 32'h1 << tb[i], r, e);
         t0 = $realtime;
         rd(`RSQ_OFS_RST_STAT, ts[i]);
         wbit(ta[i], tb[i], 1'b0);
         cmp(el >= td[i] && el <= td[i] + 6, 1'b1);
         if (i == 0) rd(`RSQ_OFS_EEPROM_COMMAND_REG, 32'h80000000);
         wbit(`RSQ_OFS_EEPROM_COMMAND_REG, 31, 1'b0);
         wbit(`RSQ_OFS_POWER_MGMT_CONTROL_REG, 0, 1'b1);
         rd(`RSQ_OFS_STRAPS, 32'hA5);
      end
      for (i = 1; i < 3; i++) begin
         u_rsq_host.xfer(1'b1, `RSQ_OFS_POWER_MGMT_CONTROL_REG, i << 12, r, e);
         rd(`RSQ_OFS_POWER_MGMT_CONTROL_REG, i << 12);
         u_rsq_host.xfer(1'b1, `RSQ_OFS_WAKE_TEST, 32'h0, r, e);
         t0 = $realtime;
         wbit(`RSQ_OFS_POWER_MGMT_CONTROL_REG, 0, 1'b1);
         cmp(el >= WAKE && el <= WAKE + 6, 1'b1);
         rd(`RSQ_OFS_POWER_MGMT_CONTROL_REG, 32'h1);
      end
      u_rsq_host.xfer(1'b1, 12'h01C, 32'hFFFFFFFF, r, e);
      cmp(e, 1'b1);
      rd(12'h01C, 32'h0);
      fork
         u_rsq_host.pin_reset(20, 8'h5A);
         begin
            repeat (6) @(posedge pclk);
            rd(`RSQ_OFS_POWER_MGMT_CONTROL_REG, 32'h0);
            rd(`RSQ_OFS_RST_STAT, 32'h3F);
         end
      join
      t0 = $realtime;
      repeat (4) @(posedge pclk);
      rd(`RSQ_OFS_EEPROM_COMMAND_REG, 32'h80000000);
      wbit(`RSQ_OFS_POWER_MGMT_CONTROL_REG, 0, 1'b1);
      cmp(el <= RDY + 12, 1'b1);
      rd(`RSQ_OFS_STRAPS, 32'h5A);
      tally_and_finish;
   end
endmodule // rsq_top_tb
`default_nettype wire
